// File: verilog/irq_src_pkg.sv
// constants, register map and field positions of the interrupt source block
package irq_src_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // apb byte offsets
  localparam logic [11:0] OFS_RESET_CAUSE = 12'h000;
  localparam logic [11:0] OFS_CTL_MAIN = 12'h004;
  localparam logic [11:0] OFS_CTL_SECOND = 12'h008;
  localparam logic [11:0] OFS_CTL_THIRD = 12'h00c;
  localparam logic [11:0] OFS_TIMER_CTL = 12'h010;
  localparam logic [11:0] OFS_TIMER_CNT = 12'h014;
  localparam logic [11:0] OFS_CONTEXT = 12'h018;
  localparam logic [11:0] OFS_RET_ADDR = 12'h01c;
  // reset cause register fields
  localparam int RC_PRIO_ON = 7;
  localparam int RC_SW_BOR = 6;
  localparam int RC_RESET_INSTR = 4;
  localparam int RC_WDT = 3;
  localparam int RC_PD = 2;
  localparam int RC_POR = 1;
  localparam int RC_BOR = 0;
  localparam logic [7:0] RC_WRITE_MASK = 8'hd3;
  localparam logic [7:0] RC_RST = 8'h1c;
  // bit 5 is unimplemented and reads 0
  localparam logic [7:0] RC_READ_MASK = 8'hdf;
  // main control fields
  localparam int M_GLOBAL_EN = 7;
  localparam int M_PERIPH_EN = 6;
  localparam int M_TMR_EN = 5;
  localparam int M_EXT0_EN = 4;
  localparam int M_PC_EN = 3;
  localparam int M_TMR_FLAG = 2;
  localparam int M_EXT0_FLAG = 1;
  localparam int M_PC_FLAG = 0;
  // second control fields
  localparam int S_EDGE0 = 6;
  localparam int S_EDGE1 = 5;
  localparam int S_EDGE2 = 4;
  localparam int S_TMR_PRIO = 2;
  localparam int S_PC_PRIO = 0;
  // third control fields
  localparam int T_EXT2_PRIO = 7;
  localparam int T_EXT1_PRIO = 6;
  localparam int T_EXT2_EN = 4;
  localparam int T_EXT1_EN = 3;
  localparam int T_EXT2_FLAG = 1;
  localparam int T_EXT1_FLAG = 0;
  // timer control fields
  localparam int TC_RUN = 7;
  localparam int TC_EIGHT_BIT = 6;
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] SECOND_RST = 8'hf5;
  localparam logic [7:0] THIRD_RST = 8'hc0;
  localparam logic [7:0] TIMER_CTL_RST = 8'hc0;
endpackage

// File: verilog/irq_ctx_if.sv
// carrier between the source logic and the context shadow store
interface irq_ctx_if;
  logic take;
  logic [7:0] working_accumulator_in;
  logic [7:0] status_in;
  logic [7:0] bsr_in;
  logic [20:0] pc_in;
  logic [7:0] working_accumulator_sh;
  logic [7:0] status_sh;
  logic [7:0] bsr_sh;
  logic [20:0] ret_top;
  modport src (output take, working_accumulator_in, status_in, bsr_in, pc_in,
    input working_accumulator_sh, status_sh, bsr_sh, ret_top);
  modport store (input take, working_accumulator_in, status_in, bsr_in, pc_in,
    output working_accumulator_sh, status_sh, bsr_sh, ret_top);
endinterface

// File: verilog/irq_ctx_store.sv
// return address stack and fast return shadow registers
module irq_ctx_store #(
  parameter int DEPTH = 31
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pop,
  irq_ctx_if.store ctx
);
  localparam int PW = $clog2(DEPTH + 1);
  logic [20:0] stack_r [DEPTH];
  logic [PW-1:0] ptr_r;
  logic [7:0] w_r;
  logic [7:0] s_r;
  logic [7:0] b_r;
  wire full = (ptr_r == PW'(DEPTH));
  wire empty = (ptr_r == '0);

  always_ff @(posedge clock) begin
    if (ctx.take && !full) begin
      stack_r[ptr_r[PW-1:0]] <= ctx.pc_in;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ptr_r <= '0;
      w_r <= 8'h00;
      s_r <= 8'h00;
      b_r <= 8'h00;
    end else if (ctx.take) begin
      // overflow keeps the pointer; the oldest entries are safe
      if (!full) ptr_r <= ptr_r + PW'(1);
      w_r <= ctx.working_accumulator_in;
      s_r <= ctx.status_in;
      b_r <= ctx.bsr_in;
    end else if (pop && !empty) begin
      ptr_r <= ptr_r - PW'(1);
    end
  end

  assign ctx.working_accumulator_sh = w_r;
  assign ctx.status_sh = s_r;
  assign ctx.bsr_sh = b_r;
  assign ctx.ret_top = empty ? 21'h000000 : stack_r[ptr_r - PW'(1)];
endmodule // irq_ctx_store

// File: verilog/irq_sources.sv
// external, timer and pin change interrupt sources with reset cause register
//
// Our own choices: register access over APB and the register offsets.
module irq_sources (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] PIN_GROUP_B,
  input wire logic TIMER_TICK,
  input wire logic RESET_INSTR_EVT,
  input wire logic WATCHDOG_EVT,
  input wire logic SLEEP_ENTER,
  input wire logic POWER_ON_RESET,
  input wire logic BROWNOUT_RESET,
  input wire logic SW_BOR_ALLOWED,
  input wire logic IRQ_ACK,
  input wire logic IRQ_RETURN,
  input wire logic [7:0] CORE_WORKING_ACCUMULATOR,
  input wire logic [7:0] CORE_STATUS,
  input wire logic [7:0] CORE_BSR,
  input wire logic [20:0] CORE_PC,
  output logic IRQ_HIGH,
  output logic IRQ_LOW,
  output logic WAKE,
  output logic SLEEPING,
  output logic [20:0] RETURN_ADDR
);
  // two stage synchronisers for pins
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [7:0] pin_d_r;
  logic [7:0] rc_r;
  logic [7:0] main_r;
  logic [7:0] second_r;
  logic [7:0] third_r;
  logic [7:0] tctl_r;
  logic [15:0] tcnt_r;
  logic [3:0] pc_ref_r;
  logic [2:0] wake_armed_r;
  logic sleep_r;
  logic por_seen_r;
  logic [31:0] rdata_r;
  logic [2:0] prime_r;

  irq_ctx_if ctx ();

  irq_ctx_store #(.DEPTH(31)) u_ctx (
    .clock(CLOCK),
    .rst_n(RST_N),
    .pop(IRQ_RETURN),
    .ctx(ctx)
  );

  function automatic logic edge_hit(input logic pol, input logic prev, input logic cur);
    edge_hit = pol ? (!prev && cur) : (prev && !cur);
  endfunction

  // apb decode
  wire acc = PSEL && PENABLE;
  wire wr = acc && PWRITE;
  wire hit_rc = (PADDR == irq_src_pkg::OFS_RESET_CAUSE);
  wire hit_main = (PADDR == irq_src_pkg::OFS_CTL_MAIN);
  wire hit_second = (PADDR == irq_src_pkg::OFS_CTL_SECOND);
  wire hit_third = (PADDR == irq_src_pkg::OFS_CTL_THIRD);
  wire hit_tctl = (PADDR == irq_src_pkg::OFS_TIMER_CTL);
  wire hit_tcnt = (PADDR == irq_src_pkg::OFS_TIMER_CNT);
  wire hit_ctx = (PADDR == irq_src_pkg::OFS_CONTEXT);
  wire hit_ret = (PADDR == irq_src_pkg::OFS_RET_ADDR);
  wire mapped = hit_rc | hit_main | hit_second | hit_third | hit_tctl | hit_tcnt
    | hit_ctx | hit_ret;

  // edge and change detection
  // a pin held high over reset would otherwise look like an edge
  wire sync_ok = &prime_r;
  wire ev_ext0 = sync_ok
    && edge_hit(second_r[irq_src_pkg::S_EDGE0], pin_d_r[0], pin_s2_r[0]);
  wire ev_ext1 = sync_ok
    && edge_hit(second_r[irq_src_pkg::S_EDGE1], pin_d_r[1], pin_s2_r[1]);
  wire ev_ext2 = sync_ok
    && edge_hit(second_r[irq_src_pkg::S_EDGE2], pin_d_r[2], pin_s2_r[2]);
  wire ev_pc = sync_ok && (pin_s2_r[7:4] != pc_ref_r);

  // timer overflow in either width
  wire t_run = tctl_r[irq_src_pkg::TC_RUN] && TIMER_TICK;
  wire t8 = tctl_r[irq_src_pkg::TC_EIGHT_BIT];
  wire ev_tmr = t_run && (t8 ? (tcnt_r[7:0] == 8'hff) : (tcnt_r == 16'hffff));
  wire [15:0] tcnt_inc = tcnt_r + 16'h0001;
  wire [15:0] tcnt_step = t8 ? {tcnt_r[15:8], tcnt_inc[7:0]} : tcnt_inc;

  // requests: flag and enable; priority routing
  wire rq_ext0 = main_r[irq_src_pkg::M_EXT0_FLAG] && main_r[irq_src_pkg::M_EXT0_EN];
  wire rq_ext1 = third_r[irq_src_pkg::T_EXT1_FLAG] && third_r[irq_src_pkg::T_EXT1_EN];
  wire rq_ext2 = third_r[irq_src_pkg::T_EXT2_FLAG] && third_r[irq_src_pkg::T_EXT2_EN];
  wire rq_tmr = main_r[irq_src_pkg::M_TMR_FLAG] && main_r[irq_src_pkg::M_TMR_EN];
  wire rq_pc = main_r[irq_src_pkg::M_PC_FLAG] && main_r[irq_src_pkg::M_PC_EN];
  wire prio_on = rc_r[irq_src_pkg::RC_PRIO_ON];
  wire p1 = third_r[irq_src_pkg::T_EXT1_PRIO];
  wire p2 = third_r[irq_src_pkg::T_EXT2_PRIO];
  wire pt = second_r[irq_src_pkg::S_TMR_PRIO];
  wire pp = second_r[irq_src_pkg::S_PC_PRIO];
  // ext zero joins the high group unconditionally
  wire any_hi = rq_ext0 | (rq_ext1 & p1) | (rq_ext2 & p2) | (rq_tmr & pt) | (rq_pc & pp);
  wire any_lo = (rq_ext1 & !p1) | (rq_ext2 & !p2) | (rq_tmr & !pt) | (rq_pc & !pp);
  wire any_rq = any_hi | any_lo;
  wire global_irq_enable = main_r[irq_src_pkg::M_GLOBAL_EN];
  wire peie = main_r[irq_src_pkg::M_PERIPH_EN];
  // compatibility mode: one level, all on the high line
  wire req_hi = prio_on ? (global_irq_enable && any_hi) : (global_irq_enable && any_rq);
  wire req_lo = prio_on && peie && any_lo;
  wire ext_wake = |(wake_armed_r & {rq_ext2, rq_ext1, rq_ext0});

  // register write data
  wire [7:0] wd = PWDATA[7:0];
  wire [7:0] hw_main = {5'h00, ev_tmr, ev_ext0, ev_pc} << irq_src_pkg::M_PC_FLAG;
  wire [7:0] main_set = main_r | hw_main;
  wire [7:0] main_nxt = (wr && hit_main) ? (wd | hw_main) : main_set;
  wire [7:0] third_hw = {6'h00, ev_ext2, ev_ext1};
  wire [7:0] third_nxt = (wr && hit_third) ? (wd | third_hw) : (third_r | third_hw);
  wire [7:0] rc_sw = (rc_r & ~irq_src_pkg::RC_WRITE_MASK) | (wd & irq_src_pkg::RC_WRITE_MASK);
  wire [7:0] rc_hw = {3'h0, RESET_INSTR_EVT, WATCHDOG_EVT, 3'h0};

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pin_d_r <= 8'h00;
      pc_ref_r <= 4'h0;
      prime_r <= 3'h0;
    end else begin
      prime_r <= {prime_r[1:0], 1'b1};
      pin_s1_r <= PIN_GROUP_B;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
      pc_ref_r <= pin_s2_r[7:4];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      main_r <= irq_src_pkg::MAIN_RST;
      second_r <= irq_src_pkg::SECOND_RST;
      third_r <= irq_src_pkg::THIRD_RST;
      tctl_r <= irq_src_pkg::TIMER_CTL_RST;
      tcnt_r <= 16'h0000;
    end else begin
      main_r <= main_nxt;
      third_r <= third_nxt;
      if (wr && hit_second) second_r <= wd;
      if (wr && hit_tctl) tctl_r <= wd;
      if (wr && hit_tcnt) tcnt_r <= PWDATA[15:0];
      else if (t_run) tcnt_r <= tcnt_step;
    end
  end

  // reset cause: RC_RST loads first; the reset inputs then decide the RC_POR, RC_BOR and RC_SW_BOR bits
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rc_r <= irq_src_pkg::RC_RST;
      por_seen_r <= 1'b0;
    end else begin
      if (!por_seen_r) begin
        por_seen_r <= 1'b1;
        rc_r[irq_src_pkg::RC_POR] <= !POWER_ON_RESET;
        rc_r[irq_src_pkg::RC_BOR] <= !BROWNOUT_RESET;
        rc_r[irq_src_pkg::RC_SW_BOR] <= SW_BOR_ALLOWED;
      end else if (wr && hit_rc) begin
        rc_r <= rc_sw & ~rc_hw;
      end else begin
        rc_r <= rc_r & ~rc_hw;
      end
      if (SLEEP_ENTER) rc_r[irq_src_pkg::RC_PD] <= 1'b0;
    end
  end

  // sleep and wake: arming sampled on entry
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sleep_r <= 1'b0;
      wake_armed_r <= 3'h0;
    end else if (SLEEP_ENTER && !sleep_r) begin
      sleep_r <= 1'b1;
      wake_armed_r <= {third_r[irq_src_pkg::T_EXT2_EN], third_r[irq_src_pkg::T_EXT1_EN],
        main_r[irq_src_pkg::M_EXT0_EN]};
    end else if (sleep_r && ext_wake) begin
      sleep_r <= 1'b0;
      wake_armed_r <= 3'h0;
    end
  end

  assign ctx.take = IRQ_ACK;
  assign ctx.working_accumulator_in = CORE_WORKING_ACCUMULATOR;
  assign ctx.status_in = CORE_STATUS;
  assign ctx.bsr_in = CORE_BSR;
  assign ctx.pc_in = CORE_PC;

  // read mux
  wire [7:0] rd_sel = hit_rc ? (rc_r & irq_src_pkg::RC_READ_MASK) :
    hit_main ? main_r :
    hit_second ? second_r :
    hit_third ? third_r :
    hit_tctl ? tctl_r :
    hit_tcnt ? tcnt_r[7:0] :
    hit_ctx ? ctx.working_accumulator_sh : 8'h00;
  wire [31:0] rd_wide = hit_tcnt ? {16'h0000, tcnt_r} :
    hit_ctx ? {8'h00, ctx.bsr_sh, ctx.status_sh, ctx.working_accumulator_sh} :
    hit_ret ? {11'h000, ctx.ret_top} : {24'h000000, rd_sel};

  // snapshot at the end of setup keeps zero wait; a flag set on that edge shows next read
  wire setup_rd = PSEL && !PENABLE && !PWRITE && mapped;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= setup_rd ? rd_wide : 32'h00000000;
    end
  end

  assign PRDATA = rdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !mapped;
  // high vector taken only with global enable, low vector with the peripheral enable alone in priority mode; plain wake otherwise
  assign IRQ_HIGH = req_hi && !sleep_r;
  assign IRQ_LOW = req_lo && !sleep_r;
  assign WAKE = sleep_r && ext_wake;
  assign SLEEPING = sleep_r;
  assign RETURN_ADDR = ctx.ret_top;
endmodule // irq_sources

// File: tb/irq_sources_monitor.sv
// assertion checker on the top ports of the interrupt source block
module irq_sources_monitor (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic SLEEP_ENTER,
  input wire logic IRQ_ACK,
  input wire logic IRQ_RETURN,
  input wire logic [20:0] CORE_PC,
  input wire logic IRQ_HIGH,
  input wire logic IRQ_LOW,
  input wire logic WAKE,
  input wire logic SLEEPING,
  input wire logic [20:0] RETURN_ADDR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire logic acc = PSEL && PENABLE;
  property p_quiet; SLEEPING |-> !IRQ_HIGH && !IRQ_LOW; endproperty
  a_quiet: assert property (p_quiet) else $error("request while asleep");
  property p_wake; WAKE |-> SLEEPING; endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_sleep; $rose(SLEEPING) |-> $past(SLEEP_ENTER); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without request");
  property p_push; IRQ_ACK && !IRQ_RETURN |=> RETURN_ADDR == $past(CORE_PC); endproperty
  a_push: assert property (p_push) else $error("return address not pushed");
  property p_hold; !IRQ_ACK && !IRQ_RETURN |=> $stable(RETURN_ADDR); endproperty
  a_hold: assert property (p_hold) else $error("stack moved unasked");
  property p_err; PSLVERR |-> acc; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_unmap; acc && PADDR > 12'h01c |-> PSLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
  property p_idle; !acc |-> PRDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_rc;
    acc && !PWRITE && PADDR == irq_src_pkg::OFS_RESET_CAUSE |-> PRDATA[31:8] == 24'h0 && !PRDATA[5];
  endproperty
  a_rc: assert property (p_rc) else $error("unused reset cause bits set");
  c_ack: cover property (IRQ_ACK);
  c_wake: cover property (WAKE);
  c_err: cover property (PSLVERR);
endmodule // irq_sources_monitor

bind irq_sources irq_sources_monitor u_irq_sources_monitor (.CLOCK, .RST_N, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PRDATA, .PSLVERR, .SLEEP_ENTER, .IRQ_ACK, .IRQ_RETURN, .CORE_PC,
  .IRQ_HIGH, .IRQ_LOW, .WAKE, .SLEEPING, .RETURN_ADDR);

// File: tb/core_model.sv
// behavioural processor core answering the request lines
module core_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic [31:0] seed,
  output logic irq_ack,
  output logic irq_return,
  output logic [20:0] core_pc,
  output logic [23:0] core_regs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_r;
  logic [1:0] wait_r;
  wire logic req = irq_high || irq_low;
  assign core_pc = seed[20:0];
  assign core_regs = seed[23:0];
  // latency of zero to three cycles so slow and prompt takes both occur
  always @(posedge clock) begin
    irq_ack <= 1'b0;
    irq_return <= 1'b0;
    if (!rst_n) begin
      busy_r <= 1'b0;
      wait_r <= 2'h0;
    end else if (!busy_r && req) begin
      wait_r <= wait_r + 2'h1;
      if (wait_r == seed[31:30]) begin
        irq_ack <= 1'b1;
        busy_r <= 1'b1;
      end
    end else if (busy_r && !req) begin
      irq_return <= 1'b1;
      busy_r <= 1'b0;
      wait_r <= 2'h0;
    end
  end
endmodule // core_model

// File: tb/interrupt_sources_reset_flags_tb.sv
// self-checking bench for the interrupt source block
module interrupt_sources_reset_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] rc_ofs = irq_src_pkg::OFS_RESET_CAUSE;
  localparam logic [11:0] main_ofs = irq_src_pkg::OFS_CTL_MAIN;
  localparam logic [11:0] sec_ofs = irq_src_pkg::OFS_CTL_SECOND;
  localparam logic [11:0] thr_ofs = irq_src_pkg::OFS_CTL_THIRD;
  localparam logic [11:0] cnt_ofs = irq_src_pkg::OFS_TIMER_CNT;
  logic CLOCK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, seed = 32'h0, rs = 32'he1da;
  logic PREADY, PSLVERR, IRQ_ACK, IRQ_RETURN, IRQ_HIGH, IRQ_LOW, WAKE, SLEEPING;
  logic [7:0] PIN_GROUP_B = 8'h00;
  logic TIMER_TICK = 1'b0, RESET_INSTR_EVT = 1'b0, WATCHDOG_EVT = 1'b0, SLEEP_ENTER = 1'b0;
  logic POWER_ON_RESET = 1'b1, BROWNOUT_RESET = 1'b1, SW_BOR_ALLOWED = 1'b1;
  logic [20:0] CORE_PC, RETURN_ADDR;
  logic [23:0] regs;
  // main, second, third control values and expected {high, low}
  logic [31:0] tbl [10] = '{32'hd2000002, 32'hc0000901, 32'hc0004902, 32'hc0009202,
    32'hc0004100, 32'he4040002, 32'hc4040000, 32'hc9000001, 32'hc9010002, 32'h80000900};
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #5 CLOCK = ~CLOCK;
  irq_sources u_irq_sources (.CLOCK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .PIN_GROUP_B, .TIMER_TICK, .RESET_INSTR_EVT, .WATCHDOG_EVT,
    .SLEEP_ENTER, .POWER_ON_RESET, .BROWNOUT_RESET, .SW_BOR_ALLOWED,
    .IRQ_ACK, .IRQ_RETURN, .CORE_WORKING_ACCUMULATOR(regs[7:0]), .CORE_STATUS(regs[15:8]),
    .CORE_BSR(regs[23:16]), .CORE_PC, .IRQ_HIGH, .IRQ_LOW, .WAKE, .SLEEPING, .RETURN_ADDR);
  core_model u_core_model (.clock(CLOCK), .rst_n(RST_N), .irq_high(IRQ_HIGH),
    .irq_low(IRQ_LOW), .seed, .irq_ack(IRQ_ACK), .irq_return(IRQ_RETURN),
    .core_pc(CORE_PC), .core_regs(regs));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [31:0] rc_after(input logic [31:0] old, input logic [31:0] w);
    return (w & {24'h0, irq_src_pkg::RC_WRITE_MASK}) | (old & {24'h0, ~irq_src_pkg::RC_WRITE_MASK});
  endfunction
  function automatic logic [31:0] fbit(input int i);
    return (i == 1) ? 32'h1 : 32'h2;
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, x & m);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic tick();
    TIMER_TICK <= 1'b1;
    @(posedge CLOCK);
    TIMER_TICK <= 1'b0;
  endtask
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] q;
    logic e;
    wt(12);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    rd(rc_ofs, 32'h5c);
    rd(main_ofs, {24'h0, irq_src_pkg::MAIN_RST});
    rd(sec_ofs, {24'h0, irq_src_pkg::SECOND_RST});
    rd(thr_ofs, {24'h0, irq_src_pkg::THIRD_RST});
    wr(rc_ofs, 32'hff);
    rd(rc_ofs, rc_after(32'h1c, 32'hff), 32'hbf);
    RESET_INSTR_EVT <= 1'b1;
    WATCHDOG_EVT <= 1'b1;
    @(posedge CLOCK);
    RESET_INSTR_EVT <= 1'b0;
    WATCHDOG_EVT <= 1'b0;
    rd(rc_ofs, 32'hc7, 32'hbf);
    wr(rc_ofs, 32'h80);
    rd(rc_ofs, rc_after(32'hc7, 32'h80), 32'hbf);
    apb(1'b0, 12'h020, 32'h0, q, e);
    chk({31'h0, e} | q, 32'h1);
    for (int i = 0; i < 3; i++) begin
      for (int p = 0; p < 2; p++) begin
        wr(sec_ofs, p ? 32'hf5 : 32'h85);
        PIN_GROUP_B[i] <= p[0];
        wt(4);
        wr(main_ofs, 32'h0);
        wr(thr_ofs, 32'hc0);
        PIN_GROUP_B[i] <= !p[0];
        wt(4);
        rd(i ? thr_ofs : main_ofs, 32'h0, fbit(i));
        PIN_GROUP_B[i] <= p[0];
        wt(4);
        rd(i ? thr_ofs : main_ofs, fbit(i), fbit(i));
      end
    end
    wr(main_ofs, 32'h0);
    rd(main_ofs, 32'h0, 32'h1);
    rs = nxt(rs);
    PIN_GROUP_B[7:4] <= PIN_GROUP_B[7:4] ^ (rs[3:0] | 4'h1);
    wt(4);
    rd(main_ofs, 32'h1, 32'h1);
    wr(cnt_ofs, 32'hfe);
    tick();
    rd(main_ofs, 32'h0, 32'h4);
    tick();
    rd(main_ofs, 32'h4, 32'h4);
    wr(main_ofs, 32'h0);
    wr(irq_src_pkg::OFS_TIMER_CTL, 32'h80);
    wr(cnt_ofs, 32'hff);
    tick();
    rd(main_ofs, 32'h0, 32'h4);
    wr(cnt_ofs, 32'hffff);
    tick();
    rd(main_ofs, 32'h4, 32'h4);
    foreach (tbl[k]) begin
      wr(main_ofs, {24'h0, tbl[k][31:24]});
      wr(sec_ofs, {24'h0, tbl[k][23:16]});
      wr(thr_ofs, {24'h0, tbl[k][15:8]});
      chk({30'h0, IRQ_HIGH, IRQ_LOW}, {24'h0, tbl[k][7:0]});
    end
    wr(main_ofs, 32'h0);
    wr(thr_ofs, 32'h0);
    for (int k = 0; k < 3; k++) begin
      rs = nxt(rs);
      seed <= rs;
      wr(main_ofs, 32'hd2);
      wt(8);
      rd(irq_src_pkg::OFS_RET_ADDR, {11'h0, rs[20:0]});
      rd(irq_src_pkg::OFS_CONTEXT, {8'h0, rs[23:0]});
      wr(main_ofs, 32'h0);
      wt(8);
      rd(irq_src_pkg::OFS_RET_ADDR, 32'h0);
    end
    PIN_GROUP_B[2] <= 1'b0;
    wt(4);
    wr(thr_ofs, 32'h10);
    wr(sec_ofs, 32'hf5);
    SLEEP_ENTER <= 1'b1;
    @(posedge CLOCK);
    SLEEP_ENTER <= 1'b0;
    PIN_GROUP_B[2] <= 1'b1;
    for (int n = 0; n < 20 && WAKE !== 1'b1; n++) @(posedge CLOCK);
    chk({30'h0, WAKE, IRQ_HIGH | IRQ_LOW}, 32'h2);
    wt(1);
    chk({30'h0, SLEEPING, IRQ_HIGH | IRQ_LOW}, 32'h0);
    wr(main_ofs, 32'hc0);
    chk({30'h0, IRQ_HIGH, IRQ_LOW}, 32'h1);
    rd(rc_ofs, 32'h80, 32'hbf);
    wr(rc_ofs, 32'h0);
    chk({30'h0, IRQ_HIGH, IRQ_LOW}, 32'h2);
    POWER_ON_RESET <= 1'b0;
    SW_BOR_ALLOWED <= 1'b0;
    RST_N <= 1'b0;
    wt(3);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    rd(rc_ofs, 32'h1e);
    rd(thr_ofs, {24'h0, irq_src_pkg::THIRD_RST});
    rd(main_ofs, {24'h0, irq_src_pkg::MAIN_RST});
    end_sim();
  end
endmodule // interrupt_sources_reset_flags_tb
